/* src/lblu_cfg.svh */
// Constants for the ladder bit logic unit: opcodes, operand classes, error codes, sizes
`ifndef LBLU_CFG_SVH
`define LBLU_CFG_SVH
// ----------------------------------------
// Opcodes of the contact instructions and the series block join
// ----------------------------------------
`define LBLU_OP_LOAD_CONTACT 4'h0
`define LBLU_OP_LOAD_INVERTED 4'h1
`define LBLU_OP_AND_CONTACT 4'h2
`define LBLU_OP_AND_INVERTED 4'h3
`define LBLU_OP_OR_CONTACT 4'h4
`define LBLU_OP_OR_INVERTED 4'h5
`define LBLU_OP_SERIES_BLOCK_JOIN 4'h6
// ----------------------------------------
// Operand classes
// ----------------------------------------
`define LBLU_CLS_INPUT 3'h0
`define LBLU_CLS_OUTPUT 3'h1
`define LBLU_CLS_RELAY 3'h2
`define LBLU_CLS_TIMER 3'h3
`define LBLU_CLS_COUNTER 3'h4
// ----------------------------------------
// Error codes and sizes
// ----------------------------------------
`define LBLU_ERR_NONE 16'h0000
`define LBLU_ERR_STACK_OVERFLOW 16'h2035
`define LBLU_ERR_STACK_EMPTY 16'h3000
`define LBLU_ERR_BAD_OPERAND 16'h300D
`define LBLU_ERR_BAD_OPCODE 16'h3015
`define LBLU_STACK_DEPTH 8
`define LBLU_IDX_W 8
`endif

/* src/lblu_pkg.sv */
// Types shared by the ladder bit logic unit
package lblu_pkg;
  typedef logic [3:0] lblu_op_t;
  typedef logic [2:0] lblu_cls_t;
  typedef logic [15:0] lblu_err_t;
endpackage

/* src/lblu_stack_if.sv */
// Interface between the decoder and its block stack
`timescale 1ns/100ps
interface lblu_stack_if;
  logic push;
  logic pop;
  logic push_bit;
  logic top_bit;
  logic full;
  logic empty;
  modport ctrl (output push, output pop, output push_bit, input top_bit, input full, input empty);
  modport stack (input push, input pop, input push_bit, output top_bit, output full, output empty);
endinterface

/* src/lblu_block_stack.sv */
// Block stack holding saved block results for series joins
`timescale 1ns/100ps
`include "lblu_cfg.svh"
module lblu_block_stack #(
  parameter int DEPTH = `LBLU_STACK_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  lblu_stack_if.stack s
);
  import lblu_pkg::*;
  localparam int CW = $clog2(DEPTH + 1);
  logic [DEPTH-1:0] mem;
  logic [DEPTH-1:0] next_mem;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // ----------------------------------------
  // Push and pop
  // ----------------------------------------
  // Push is ignored when full and pop when empty; the caller reports those
  always_comb begin
    next_mem = mem;
    next_count = count;
    if (s.push && !s.full) begin
      next_mem[count[$clog2(DEPTH)-1:0]] = s.push_bit;
      next_count = count + CW'(1);
    end else if (s.pop && !s.empty) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mem <= '0;
      count <= '0;
    end else if (i_ce) begin
      mem <= next_mem;
      count <= next_count;
    end
  end

  assign s.full = (count == CW'(DEPTH));
  assign s.empty = (count == '0);
  assign s.top_bit = s.empty ? 1'b0 : mem[count[$clog2(DEPTH)-1:0] - 1'b1];

  stack_bound_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) count <= CW'(DEPTH))
    else $error("block stack count beyond depth");
endmodule // lblu_block_stack

/* src/lblu_unit.sv */
// Ladder bit logic unit: contact instructions and series block join
`timescale 1ns/100ps
`include "lblu_cfg.svh"
module lblu_unit #(
  parameter int IDX_W = `LBLU_IDX_W,
  parameter int DEPTH = `LBLU_STACK_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire lblu_pkg::lblu_op_t i_opcode,
  input wire lblu_pkg::lblu_cls_t i_operand_class,
  input wire logic [IDX_W-1:0] i_operand_index,
  input wire logic i_scan_start,
  input wire logic [(1<<IDX_W)-1:0] i_input_bits,
  input wire logic [(1<<IDX_W)-1:0] i_output_bits,
  input wire logic [(1<<IDX_W)-1:0] i_relay_bits,
  input wire logic [(1<<IDX_W)-1:0] i_timer_done_bits,
  input wire logic [(1<<IDX_W)-1:0] i_counter_done_bits,
  output logic o_result,
  output logic o_done,
  output logic o_chain_active,
  output logic o_error,
  output lblu_pkg::lblu_err_t o_error_code
);
  import lblu_pkg::*;

  lblu_stack_if stk ();

  lblu_block_stack #(.DEPTH(DEPTH)) u_stack (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .s(stk)
  );

  logic operand_bit;
  logic operand_ok;
  logic next_result;
  logic next_done;
  logic next_chain;
  logic next_error;
  lblu_err_t next_code;

  // ----------------------------------------
  // Operand fetch
  // ----------------------------------------
  // One bit out of the selected memory class; unknown class is an error
  always_comb begin
    operand_bit = 1'b0;
    operand_ok = 1'b1;
    unique case (i_operand_class)
      `LBLU_CLS_INPUT: operand_bit = i_input_bits[i_operand_index];
      `LBLU_CLS_OUTPUT: operand_bit = i_output_bits[i_operand_index];
      `LBLU_CLS_RELAY: operand_bit = i_relay_bits[i_operand_index];
      `LBLU_CLS_TIMER: operand_bit = i_timer_done_bits[i_operand_index];
      `LBLU_CLS_COUNTER: operand_bit = i_counter_done_bits[i_operand_index];
      default: operand_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Instruction evaluation
  // ----------------------------------------
  // One instruction per valid cycle; errors leave the result untouched so a
  // faulty program step cannot corrupt the rung being evaluated.
  always_comb begin
    next_result = o_result;
    next_done = 1'b0;
    next_chain = o_chain_active;
    next_error = 1'b0;
    next_code = o_error_code;
    stk.push = 1'b0;
    stk.pop = 1'b0;
    stk.push_bit = o_result;
    if (i_scan_start) begin
      next_chain = 1'b0;
      next_code = `LBLU_ERR_NONE;
    end else if (i_instr_valid) begin
      next_done = 1'b1;
      if (i_opcode == `LBLU_OP_SERIES_BLOCK_JOIN) begin
        // No operand fields are looked at here
        if (stk.empty) begin
          next_error = 1'b1;
          next_code = `LBLU_ERR_STACK_EMPTY;
        end else begin
          stk.pop = 1'b1;
          next_result = o_result & stk.top_bit;
        end
      end else if (i_opcode > `LBLU_OP_SERIES_BLOCK_JOIN) begin
        next_error = 1'b1;
        next_code = `LBLU_ERR_BAD_OPCODE;
      end else if (!operand_ok) begin
        next_error = 1'b1;
        next_code = `LBLU_ERR_BAD_OPERAND;
      end else if (i_opcode == `LBLU_OP_LOAD_CONTACT || i_opcode == `LBLU_OP_LOAD_INVERTED) begin
        if (o_chain_active && stk.full) begin
          next_error = 1'b1;
          next_code = `LBLU_ERR_STACK_OVERFLOW;
        end else begin
          stk.push = o_chain_active;
          next_chain = 1'b1;
          if (i_opcode == `LBLU_OP_LOAD_CONTACT) begin
            next_result = operand_bit;
          end else begin
            next_result = ~operand_bit;
          end
        end
      end else begin
        // Series and parallel contacts assume an open chain
        unique case (i_opcode)
          `LBLU_OP_AND_CONTACT: next_result = o_result & operand_bit;
          `LBLU_OP_AND_INVERTED: next_result = o_result & ~operand_bit;
          `LBLU_OP_OR_CONTACT: next_result = o_result | operand_bit;
          default: next_result = o_result | ~operand_bit;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_result <= 1'b0;
      o_done <= 1'b0;
      o_chain_active <= 1'b0;
      o_error <= 1'b0;
      o_error_code <= `LBLU_ERR_NONE;
    end else if (i_ce) begin
      o_result <= next_result;
      o_done <= next_done;
      o_chain_active <= next_chain;
      o_error <= next_error;
      o_error_code <= next_code;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  logic ok_past;
  assign ok_past = i_ce && i_instr_valid && !i_scan_start && operand_ok;
  // Both load kinds open blocks, so the stack checks must watch both
  logic is_load;
  assign is_load = (i_opcode == `LBLU_OP_LOAD_CONTACT) || (i_opcode == `LBLU_OP_LOAD_INVERTED);

  load_direct_a: assert property (ok_past && i_opcode == `LBLU_OP_LOAD_CONTACT && !(o_chain_active && stk.full)
    |=> o_result == $past(operand_bit)) else $error("load did not copy operand");
  load_inverted_a: assert property (ok_past && i_opcode == `LBLU_OP_LOAD_INVERTED && !(o_chain_active && stk.full)
    |=> o_result == !$past(operand_bit)) else $error("inverted load wrong");
  and_direct_a: assert property (ok_past && i_opcode == `LBLU_OP_AND_CONTACT
    |=> o_result == ($past(o_result) & $past(operand_bit))) else $error("series contact wrong");
  and_inverted_a: assert property (ok_past && i_opcode == `LBLU_OP_AND_INVERTED
    |=> o_result == ($past(o_result) & !$past(operand_bit))) else $error("inverted series wrong");
  or_direct_a: assert property (ok_past && i_opcode == `LBLU_OP_OR_CONTACT
    |=> o_result == ($past(o_result) | $past(operand_bit))) else $error("parallel contact wrong");
  or_inverted_a: assert property (ok_past && i_opcode == `LBLU_OP_OR_INVERTED
    |=> o_result == ($past(o_result) | !$past(operand_bit))) else $error("inverted parallel wrong");
  block_join_a: assert property (i_ce && i_instr_valid && !i_scan_start && i_opcode == `LBLU_OP_SERIES_BLOCK_JOIN
    && !stk.empty |=> o_result == ($past(o_result) & $past(stk.top_bit)) && !o_error)
    else $error("block join wrong");
  overflow_code_a: assert property (ok_past && is_load && o_chain_active && stk.full
    |=> o_error && o_error_code == `LBLU_ERR_STACK_OVERFLOW && $stable(o_result))
    else $error("overflow not reported");
  empty_join_a: assert property (i_ce && i_instr_valid && !i_scan_start && i_opcode == `LBLU_OP_SERIES_BLOCK_JOIN
    && stk.empty |=> o_error && o_error_code == `LBLU_ERR_STACK_EMPTY && $stable(o_result))
    else $error("empty join not reported");
  nested_push_a: assert property (ok_past && is_load && o_chain_active && !stk.full
    |=> !stk.empty) else $error("pending result not saved");

  // ----------------------------------------
  // Handshake, housekeeping and stack checks
  // ----------------------------------------
  // A taken instruction always answers one cycle later with a done pulse
  done_pulse_a: assert property (i_ce && i_instr_valid && !i_scan_start |=> o_done)
    else $error("no done pulse for a taken instruction");
  // Without a taken instruction neither pulse may appear
  done_idle_a: assert property (i_ce && !(i_instr_valid && !i_scan_start) |=> !o_done && !o_error)
    else $error("pulse without an instruction");
  // The error flag only ever rides on a done pulse
  error_with_done_a: assert property (o_error |-> o_done)
    else $error("error flag without done");
  // Scan start wins over an instruction in the same cycle and keeps the result
  scan_clear_a: assert property (i_ce && i_scan_start
    |=> !o_chain_active && o_error_code == `LBLU_ERR_NONE && !o_done && $stable(o_result))
    else $error("scan start did not clear chain and code");
  // With the clock enable low result, chain and error code may not move, the done pulse included
  ce_freeze_a: assert property (!i_ce
    |=> $stable(o_result) && $stable(o_done) && $stable(o_chain_active) && $stable(o_error_code))
    else $error("state moved while clock enable low");
  // Unknown opcodes are refused without touching the result
  bad_opcode_a: assert property (i_ce && i_instr_valid && !i_scan_start && i_opcode > `LBLU_OP_SERIES_BLOCK_JOIN
    |=> o_error && o_error_code == `LBLU_ERR_BAD_OPCODE && $stable(o_result))
    else $error("unknown opcode not refused");
  // The join never looks at the operand fields, so only an empty stack refuses it
  join_no_operand_a: assert property (i_ce && i_instr_valid && !i_scan_start
    && i_opcode == `LBLU_OP_SERIES_BLOCK_JOIN |=> !o_error || o_error_code == `LBLU_ERR_STACK_EMPTY)
    else $error("join refused for its operand fields");
  // A chain's first load never pushes; a later load saves exactly the pending result
  first_load_a: assert property (ok_past && is_load && !o_chain_active |-> !stk.push)
    else $error("first load pushed the stack");
  push_bit_a: assert property (stk.push |-> o_chain_active && stk.push_bit == o_result)
    else $error("pushed value is not the pending result");

  // Cover the main scenarios: joins, overflow, nested blocks and empty joins

  join_cover: cover property (i_instr_valid && i_opcode == `LBLU_OP_SERIES_BLOCK_JOIN && !stk.empty);
  overflow_cover: cover property (o_error && o_error_code == `LBLU_ERR_STACK_OVERFLOW);
  nested_cover: cover property (stk.push ##1 stk.push);
  empty_cover: cover property (o_error && o_error_code == `LBLU_ERR_STACK_EMPTY);
endmodule // lblu_unit

/* bench/lblu_unit_test.sv */
// Self-checking testbench for the ladder bit logic unit
`timescale 1ns/100ps
`include "lblu_cfg.svh"
module lblu_unit_test;
  import lblu_pkg::*;
  localparam lblu_op_t OP_LOAD = `LBLU_OP_LOAD_CONTACT;
  localparam lblu_op_t OP_LOADN = `LBLU_OP_LOAD_INVERTED;
  localparam lblu_op_t OP_AND = `LBLU_OP_AND_CONTACT;
  localparam lblu_op_t OP_ANDN = `LBLU_OP_AND_INVERTED;
  localparam lblu_op_t OP_OR = `LBLU_OP_OR_CONTACT;
  localparam lblu_op_t OP_ORN = `LBLU_OP_OR_INVERTED;
  localparam lblu_op_t OP_JOIN = `LBLU_OP_SERIES_BLOCK_JOIN;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_instr_valid = 1'b0;
  lblu_op_t i_opcode = 4'h0;
  lblu_cls_t i_operand_class = 3'h0;
  logic [7:0] i_operand_index = 8'h00;
  logic i_scan_start = 1'b0;
  logic [255:0] mem [5] = '{default: '0};
  logic o_result, o_done, o_chain_active, o_error;
  lblu_err_t o_error_code;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  lblu_unit lblu_unit_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_instr_valid(i_instr_valid),
    .i_opcode(i_opcode), .i_operand_class(i_operand_class), .i_operand_index(i_operand_index),
    .i_scan_start(i_scan_start), .i_input_bits(mem[0]), .i_output_bits(mem[1]), .i_relay_bits(mem[2]),
    .i_timer_done_bits(mem[3]), .i_counter_done_bits(mem[4]), .o_result(o_result), .o_done(o_done),
    .o_chain_active(o_chain_active), .o_error(o_error), .o_error_code(o_error_code));
  // ----------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------
  always #50 i_clk = ~i_clk;
  // A hang in a wait would otherwise never end the run
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t ns %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Drives one instruction at a falling edge; valid stays high so calls run back to back
  task automatic issue(input lblu_op_t op, input lblu_cls_t cls, input logic [7:0] idx, input logic res,
    input logic err, input lblu_err_t code);
    i_instr_valid = 1'b1;
    i_opcode = op;
    i_operand_class = cls;
    i_operand_index = idx;
    @(negedge i_clk);
    check(o_done, 1'b1, "done pulse");
    check(o_result, res, "result");
    check(o_error, err, "error flag");
    check(o_error_code, code, "error code");
  endtask
  // Starts a new scan; the stack is left as it is
  task automatic scan();
    i_instr_valid = 1'b0;
    i_scan_start = 1'b1;
    @(negedge i_clk);
    i_scan_start = 1'b0;
    check(o_error_code, 16'h0000, "code after scan");
    check(o_chain_active, 1'b0, "chain after scan");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Each contact kind and each of the five operand classes appear; X9 and T9 differ so class selection shows
  task automatic test_contacts();
    scan();
    issue(OP_LOADN, 3'h0, 8'h04, 1'b1, 1'b0, 16'h0000);
    check(o_chain_active, 1'b1, "chain open");
    scan();
    issue(OP_LOAD, 3'h0, 8'h03, 1'b1, 1'b0, 16'h0000);
    issue(OP_AND, 3'h3, 8'h09, 1'b0, 1'b0, 16'h0000);
    issue(OP_OR, 3'h4, 8'hC8, 1'b1, 1'b0, 16'h0000);
    issue(OP_ANDN, 3'h1, 8'h05, 1'b0, 1'b0, 16'h0000);
    issue(OP_ORN, 3'h3, 8'h09, 1'b1, 1'b0, 16'h0000);
    issue(OP_AND, 3'h2, 8'h07, 1'b1, 1'b0, 16'h0000);
    issue(OP_LOADN, 3'h2, 8'h07, 1'b0, 1'b0, 16'h0000);
    issue(OP_JOIN, 3'h0, 8'h00, 1'b0, 1'b0, 16'h0000);
    $display("test_contacts finished");
  endtask
  // Blocks saved and joined, then a join with nothing saved
  task automatic test_blocks();
    scan();
    issue(OP_LOAD, 3'h0, 8'h03, 1'b1, 1'b0, 16'h0000);
    issue(OP_LOADN, 3'h0, 8'h04, 1'b1, 1'b0, 16'h0000);
    issue(OP_JOIN, 3'h0, 8'h00, 1'b1, 1'b0, 16'h0000);
    issue(OP_LOAD, 3'h0, 8'h04, 1'b0, 1'b0, 16'h0000);
    issue(OP_JOIN, 3'h7, 8'hFF, 1'b0, 1'b0, 16'h0000);
    issue(OP_JOIN, 3'h0, 8'h00, 1'b0, 1'b1, `LBLU_ERR_STACK_EMPTY);
    i_instr_valid = 1'b0;
    @(negedge i_clk);
    check(o_done, 1'b0, "done is a pulse");
    $display("test_blocks finished");
  endtask
  // Eight saved blocks fill the stack; a ninth overflows, then refused codes
  task automatic test_limits();
    scan();
    issue(OP_LOAD, 3'h0, 8'h03, 1'b1, 1'b0, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      issue(OP_LOAD, 3'h0, 8'h03, 1'b1, 1'b0, 16'h0000);
    end
    issue(OP_LOADN, 3'h0, 8'h03, 1'b1, 1'b1, `LBLU_ERR_STACK_OVERFLOW);
    for (int i = 0; i < 8; i++) begin
      issue(OP_JOIN, 3'h0, 8'h00, 1'b1, 1'b0, `LBLU_ERR_STACK_OVERFLOW);
    end
    issue(OP_JOIN, 3'h0, 8'h00, 1'b1, 1'b1, `LBLU_ERR_STACK_EMPTY);
    issue(4'h7, 3'h0, 8'h04, 1'b1, 1'b1, `LBLU_ERR_BAD_OPCODE);
    issue(OP_AND, 3'h5, 8'h04, 1'b1, 1'b1, `LBLU_ERR_BAD_OPERAND);
    scan();
    $display("test_limits finished");
  endtask
  // Clock enable low freezes an offered load; a mid-run reset then empties the stack
  task automatic test_hold_and_reset();
    scan();
    issue(OP_LOAD, 3'h0, 8'h03, 1'b1, 1'b0, 16'h0000);
    issue(OP_LOAD, 3'h0, 8'h03, 1'b1, 1'b0, 16'h0000);
    i_ce = 1'b0;
    // Everything holds, the done pulse of the previous load as well
    issue(OP_LOADN, 3'h0, 8'h03, 1'b1, 1'b0, 16'h0000);
    check(o_chain_active, 1'b1, "chain held");
    i_ce = 1'b1;
    // Only the second load pushed, so one join gives 1 AND 1
    issue(OP_JOIN, 3'h0, 8'h00, 1'b1, 1'b0, 16'h0000);
    issue(OP_LOAD, 3'h0, 8'h03, 1'b1, 1'b0, 16'h0000);
    i_instr_valid = 1'b0;
    i_sys_rst = 1'b1;
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    check({o_result, o_done, o_chain_active, o_error}, 4'h0, "flags after reset");
    check(o_error_code, 16'h0000, "code after reset");
    // The saved block must be gone: a join now finds the stack empty
    issue(OP_JOIN, 3'h0, 8'h00, 1'b0, 1'b1, `LBLU_ERR_STACK_EMPTY);
    $display("test_hold_and_reset finished");
  endtask
  // ----------------------------------------
  // Main sequence and verdict
  // ----------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    mem[0][3] = 1'b1;
    mem[0][9] = 1'b1;
    mem[1][5] = 1'b1;
    mem[2][7] = 1'b1;
    mem[4][200] = 1'b1;
    repeat (3) @(negedge i_clk);
    i_sys_rst = 1'b0;
    check({o_result, o_done, o_chain_active, o_error}, 4'h0, "reset flags");
    check(o_error_code, 16'h0000, "reset code");
    test_contacts();
    test_blocks();
    test_limits();
    test_hold_and_reset();
    report_and_stop();
  end
endmodule // lblu_unit_test
